// *** hw/ctrl_mode_fault.sv ***
// operating mode, output selection and fault reporting of the controller
`timescale 1ns/100ps
module ctrl_mode_fault
    import ctrl_mode_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES,
    parameter int BLINK_COUNT = BLINK_CYCLES
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic i_run_stop_contact_input,
    input wire logic i_sp_contact,
    input wire logic [SP_W-1:0] i_sp_contact_number,
    input wire logic i_am_force_contact,
    input wire logic i_am_force_manual,
    input wire logic i_key_man,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_disp,
    input wire logic i_key_sp_write,
    input wire logic [SP_W-1:0] i_key_sp_number,
    input wire logic [OUT_W-1:0] i_stopped_preset_output,
    input wire logic [OUT_W-1:0] i_auto_output,
    input wire logic i_alarm_condition,
    input wire logic [15:0] i_pv_value,
    input wire logic i_diag_done,
    input wire logic i_ram_ok,
    input wire logic i_rom_ok,
    input wire logic i_system_data_ok,
    input wire logic i_calibration_ok,
    input wire logic [PERR_W-1:0] i_param_error_flags,
    output logic O_RUNNING,
    output logic O_MANUAL,
    output logic [SP_W-1:0] O_SP_NUMBER,
    output logic [OUT_W-1:0] O_CONTROL_OUT,
    output logic O_CONTROL_ON,
    output logic O_ALARM,
    output logic [15:0] O_PV_DISPLAY,
    output logic [PAGE_W-1:0] O_DISPLAY_PAGE,
    output logic O_POWER_FAULT,
    output logic [FAULT_W-1:0] O_FAULT_CODE,
    output logic O_COMM_HALT,
    output logic O_PV_DP_BLINK,
    output logic O_PARAM_ERROR,
    output logic [3:0] O_ERR_TENS,
    output logic [3:0] O_ERR_ONES
);
    // typed copies of the timing parameters
    // defaults give a 3 s hold and a 0.5 s blink half period
    localparam logic [TIMER_W-1:0] HOLD_LIMIT = TIMER_W'(HOLD_COUNT);
    localparam logic [TIMER_W-1:0] BLINK_LIMIT = TIMER_W'(BLINK_COUNT - 1);
    localparam logic [TIMER_W-1:0] TIMER_ONE = 26'h0000001;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 26'h0000000;

    // synchronised pin levels and key press pulses
    // every pin passes four flops, three synchroniser stages and the filter, keys also give a press pulse
    logic [PIN_W-1:0] pin_level; // filtered pin levels
    logic [PIN_W-1:0] pin_rise; // one-cycle press pulses
    wire [PIN_W-1:0] pin_raw = {i_sp_contact_number, i_key_disp, i_key_down, i_key_up, i_key_man,
                                i_am_force_manual, i_am_force_contact, i_sp_contact,
                                i_run_stop_contact_input};

    pin_sync #(
        .WIDTH(PIN_W)
    ) u_pin_sync (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_pin(pin_raw),
        .o_level(pin_level),
        .o_rise(pin_rise)
    );

    // decoded pin roles
    wire run_level = pin_level[PIN_RUN_STOP];
    wire sp_contact_on = pin_level[PIN_SP_CONTACT];
    wire [SP_W-1:0] sp_contact_num = pin_level[PIN_SP_NUM_MSB:PIN_SP_NUM_LSB];
    wire am_forced = pin_level[PIN_AM_FORCE];
    wire am_forced_man = pin_level[PIN_AM_FORCE_MAN];
    wire man_press = pin_rise[PIN_KEY_MAN];
    wire up_press = pin_rise[PIN_KEY_UP];
    wire down_press = pin_rise[PIN_KEY_DOWN];
    wire disp_press = pin_rise[PIN_KEY_DISP];
    wire disp_held = pin_level[PIN_KEY_DISP];

    // power-on diagnostic state, mode and timer registers
    diag_state_e diag_state; // sequence state
    diag_state_e next_diag_state; // next sequence state
    logic cal_bad; // latched calibration fault
    logic [PERR_W-1:0] perr_flags; // latched parameter error flags
    logic manual; // manual operation
    logic [OUT_W-1:0] manual_value; // operator-set output
    logic [TIMER_W-1:0] hold_count; // display key hold time
    logic hold_done; // hold already acted on
    logic [TIMER_W-1:0] blink_count; // blink half-period timer

    // memory and system data checks, first failure reported
    // any one of the three failing halts the controller for good
    wire mem_fault = ~i_ram_ok | ~i_rom_ok | ~i_system_data_ok;
    wire [FAULT_W-1:0] fault_sel = ~i_ram_ok ? RAM_FAULT_CODE :
                                   ~i_rom_ok ? ROM_FAULT_CODE : SYSTEM_DATA_FAULT_CODE;

    // sequence: wait for self-test, then run or halt for good
    always_comb begin
        next_diag_state = diag_state;
        unique case (diag_state)
            DIAG_WAIT: begin
                if (i_diag_done) begin
                    next_diag_state = mem_fault ? DIAG_HALT : DIAG_RUN;
                end
            end
            DIAG_RUN: begin
                next_diag_state = DIAG_RUN;
            end
            DIAG_HALT: begin
                next_diag_state = DIAG_HALT;
            end
            default: begin
                next_diag_state = DIAG_HALT;
            end
        endcase
    end

    wire diag_capture = (diag_state == DIAG_WAIT) & i_diag_done;
    wire operating = (diag_state == DIAG_RUN);
    wire halted = (diag_state == DIAG_HALT);
    wire param_err = |perr_flags;

    // state register and latched diagnostic results
    // a second done pulse is ignored until the next reset
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            diag_state <= DIAG_WAIT;
            cal_bad <= 1'b0;
            perr_flags <= '0;
            O_POWER_FAULT <= 1'b0;
            O_FAULT_CODE <= RAM_FAULT_CODE;
        end else begin
            diag_state <= next_diag_state;
            if (diag_capture) begin
                cal_bad <= ~i_calibration_ok;
                perr_flags <= i_param_error_flags; // all failing categories at once
                O_POWER_FAULT <= mem_fault;
                O_FAULT_CODE <= fault_sel;
            end
        end
    end

    // parameter error code as two decimal digits
    // all seven flags set gives 127, so the tens digit reaches 12
    wire [PERR_W-1:0] err_tens = perr_flags / DEC_TEN;
    wire [PERR_W-1:0] err_ones = perr_flags % DEC_TEN;

    // error code display
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_PARAM_ERROR <= 1'b0;
            O_ERR_TENS <= 4'h0;
            O_ERR_ONES <= 4'h0;
        end else begin
            O_PARAM_ERROR <= param_err & ~halted;
            O_ERR_TENS <= err_tens[3:0];
            O_ERR_ONES <= err_ones[3:0];
        end
    end

    // calibration blink timer, free running while the fault stands and diagnostics passed
    // timer held clear otherwise, so the point starts dark
    wire blink_wrap = (blink_count >= BLINK_LIMIT);
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            blink_count <= TIMER_ZERO;
            O_PV_DP_BLINK <= 1'b0;
        end else if (cal_bad & operating) begin
            blink_count <= blink_wrap ? TIMER_ZERO : blink_count + TIMER_ONE;
            if (blink_wrap) begin
                O_PV_DP_BLINK <= ~O_PV_DP_BLINK;
            end
        end else begin
            blink_count <= TIMER_ZERO;
            O_PV_DP_BLINK <= 1'b0;
        end
    end

    // run/stop follows the contact
    // stopping changes the output choice and locks up/down, alarm and pv go on
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_RUNNING <= 1'b0;
        end else begin
            O_RUNNING <= run_level;
        end
    end

    // setpoint number: contact wins, keystrokes only when contact off
    // a keystroke during contact selection is dropped, not queued
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_SP_NUMBER <= SP_RESET;
        end else if (sp_contact_on) begin
            O_SP_NUMBER <= sp_contact_num; // keystroke ignored
        end else if (i_key_sp_write) begin
            O_SP_NUMBER <= i_key_sp_number;
        end
    end

    // auto/manual: forcing contact overrides the key
    // a press while forced is lost, it does not act after release
    wire next_manual = am_forced ? am_forced_man : // key ignored
                       man_press ? ~manual : manual;

    // manual value: up/down only when running in manual
    // a step past either end is clamped, never wrapped
    wire adjust_ok = manual & run_level & operating;
    wire at_top = (manual_value >= OUT_FULL);
    wire at_bottom = (manual_value == OUT_ZERO);
    wire [OUT_W-1:0] value_up = at_top ? OUT_FULL : manual_value + OUT_STEP;
    wire [OUT_W-1:0] value_down = at_bottom ? OUT_ZERO : manual_value - OUT_STEP;

    // mode and manual value registers
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            manual <= 1'b0;
            manual_value <= OUT_ZERO;
        end else begin
            manual <= next_manual;
            if (next_manual & ~manual) begin
                manual_value <= O_CONTROL_OUT; // bumpless entry to manual
            end else if (adjust_ok & up_press) begin
                manual_value <= value_up;
            end else if (adjust_ok & down_press) begin
                manual_value <= value_down;
            end
        end
    end

    // output selection by priority
    // faults outrank stop, stop outranks manual, manual outranks auto
    wire force_zero = ~operating | param_err;
    wire [OUT_W-1:0] out_sel = force_zero ? OUT_ZERO :
                               ~run_level ? i_stopped_preset_output :
                               manual ? manual_value : i_auto_output;

    // control output, alarm and indicator
    // alarm held off before diagnostics pass and after a halt
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            O_MANUAL <= 1'b0;
            O_CONTROL_OUT <= OUT_ZERO;
            O_CONTROL_ON <= 1'b0;
            O_ALARM <= 1'b0;
            O_PV_DISPLAY <= 16'h0000;
            O_COMM_HALT <= 1'b0;
        end else begin
            O_MANUAL <= manual;
            O_CONTROL_OUT <= out_sel;
            O_CONTROL_ON <= ~force_zero;
            O_ALARM <= operating & i_alarm_condition; // stop does not gate it
            O_PV_DISPLAY <= i_pv_value;
            O_COMM_HALT <= halted;
        end
    end

    // display key: press steps pages, long hold returns home
    // a long hold acts once, the key must be released to act again
    wire hold_expired = (hold_count > HOLD_LIMIT);
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            hold_count <= TIMER_ZERO;
            hold_done <= 1'b0;
            O_DISPLAY_PAGE <= PAGE_OPERATING;
        end else if (!disp_held) begin
            hold_count <= TIMER_ZERO;
            hold_done <= 1'b0;
        end else begin
            if (!hold_expired) begin
                hold_count <= hold_count + TIMER_ONE;
            end
            if (hold_expired & ~hold_done) begin
                hold_done <= 1'b1;
                O_DISPLAY_PAGE <= PAGE_OPERATING;
            end else if (disp_press) begin
                O_DISPLAY_PAGE <= (O_DISPLAY_PAGE >= PAGE_LAST) ? PAGE_OPERATING : O_DISPLAY_PAGE + 3'h1;
            end
        end
    end
endmodule : ctrl_mode_fault

// *** hw/ctrl_mode_pkg.sv ***
// constants shared by the controller mode and fault logic
package ctrl_mode_pkg;
    // clock rate and derived timing
    localparam int CLK_KHZ = 20000;          // 20 MHz system clock
    localparam int HOLD_TIME_MS = 3000;      // display key hold time, 3 seconds
    localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ;
    localparam int BLINK_TIME_MS = 500;      // half period of the decimal point blink
    localparam int BLINK_CYCLES = BLINK_TIME_MS * CLK_KHZ;
    localparam int TIMER_W = 26;             // wide enough for both counts

    // pin input bit positions inside the synchroniser vector
    localparam int PIN_W = 11;
    localparam int PIN_RUN_STOP = 0;         // run_stop_contact_input, high means run
    localparam int PIN_SP_CONTACT = 1;       // setpoint selection contact active
    localparam int PIN_AM_FORCE = 2;         // auto/manual forcing contact active
    localparam int PIN_AM_FORCE_MAN = 3;     // forced mode is manual when high
    localparam int PIN_KEY_MAN = 4;          // manual-mode key
    localparam int PIN_KEY_UP = 5;           // up key
    localparam int PIN_KEY_DOWN = 6;         // down key
    localparam int PIN_KEY_DISP = 7;         // display-select key
    localparam int PIN_SP_NUM_LSB = 8;       // contact setpoint number, 3 bits
    localparam int PIN_SP_NUM_MSB = 10;

    // output value scale: tenths of a percent
    localparam int OUT_W = 10;
    localparam logic [OUT_W-1:0] OUT_ZERO = 10'h000;      // 0 %
    localparam logic [OUT_W-1:0] OUT_FULL = 10'h3E8;      // 100.0 %
    localparam logic [OUT_W-1:0] OUT_STEP = 10'h001;      // one key step, 0.1 %
    localparam logic [OUT_W-1:0] PRESET_DEFAULT = 10'h000; // factory preset, 0 %

    // setpoint numbers 1..8
    localparam int SP_W = 3;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;          // setpoint number 1

    // display pages
    localparam int PAGE_W = 3;
    localparam logic [PAGE_W-1:0] PAGE_OPERATING = 3'h0;  // page shown at power-on
    localparam logic [PAGE_W-1:0] PAGE_LAST = 3'h4;

    // power-on fault codes
    localparam int FAULT_W = 2;
    localparam logic [FAULT_W-1:0] RAM_FAULT_CODE = 2'h0;
    localparam logic [FAULT_W-1:0] ROM_FAULT_CODE = 2'h1;
    localparam logic [FAULT_W-1:0] SYSTEM_DATA_FAULT_CODE = 2'h2;

    // parameter error flag positions
    localparam int PERR_W = 7;
    localparam int PERR_CAL = 0;             // calibration data
    localparam int PERR_CUSTOM = 1;          // custom computing data
    localparam int PERR_INSTRUMENT = 2;      // instrument_mode_config
    localparam int PERR_RANGE = 3;           // range data
    localparam int PERR_SETUP = 4;           // setup parameters
    localparam int PERR_OPERATING = 5;       // operating parameters
    localparam int PERR_MODE_OUT = 6;        // operation mode/output
    localparam logic [PERR_W-1:0] DEC_TEN = 7'h0A;

    // power-on sequence states
    typedef enum logic [1:0] {
        DIAG_WAIT = 2'b00,
        DIAG_RUN = 2'b01,
        DIAG_HALT = 2'b10
    } diag_state_e;
endpackage : ctrl_mode_pkg

// *** hw/pin_sync.sv ***
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic s1; // first stage, read only by s2
            logic s2; // second stage
            logic s3; // third stage
            wire agree = (s2 == s3); // stable once two stages agree
            // shift chain and filtered level
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    o_level[g] <= 1'b0;
                    o_rise[g] <= 1'b0;
                end else begin
                    s1 <= i_pin[g];
                    s2 <= s1;
                    s3 <= s2;
                    o_rise[g] <= agree & s3 & ~o_level[g];
                    if (agree) begin
                        o_level[g] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

// *** testbench/controller_mode_and_fault_logic_test.sv ***
// self-checking bench for the mode and fault logic
`timescale 1ns/100ps
module controller_mode_and_fault_logic_test
    import ctrl_mode_pkg::*;
;
    logic clk, rst, sp_wr, alarm, done, blink_prev;
    logic [PIN_W-1:0] pins;
    logic [SP_W-1:0] sp_num, sp_out;
    logic [OUT_W-1:0] preset, auto_out, ctl_out;
    logic [15:0] pv, pv_disp;
    logic [3:0] oks, tens, ones;
    logic [PERR_W-1:0] flags;
    logic running, manual, ctl_on, alm, pfault, chalt, blink, perr;
    logic [FAULT_W-1:0] fcode;
    logic [PAGE_W-1:0] page;
    logic [3:0] bad_oks [3] = '{4'h7, 4'hB, 4'hD}; // ram, rom, system data failing
    logic [FAULT_W-1:0] codes [3] = '{RAM_FAULT_CODE, ROM_FAULT_CODE, SYSTEM_DATA_FAULT_CODE};
    logic [PERR_W-1:0] perr_tbl [3] = '{7'h21, 7'h7F, 7'h40}; // mixed, all, top bit
    int bad_count, comparisons, changes;

    // pins come from the panel model, short counts for hold and blink
    panel_model i_panel_model (.i_clk(clk), .o_pins(pins));
    ctrl_mode_fault #(.HOLD_COUNT(20), .BLINK_COUNT(4)) i_ctrl_mode_fault (.I_CLK_SYS(clk), .I_RESET(rst),
        .i_run_stop_contact_input(pins[PIN_RUN_STOP]), .i_sp_contact(pins[PIN_SP_CONTACT]),
        .i_sp_contact_number(pins[PIN_SP_NUM_MSB:PIN_SP_NUM_LSB]), .i_am_force_contact(pins[PIN_AM_FORCE]),
        .i_am_force_manual(pins[PIN_AM_FORCE_MAN]), .i_key_man(pins[PIN_KEY_MAN]), .i_key_up(pins[PIN_KEY_UP]),
        .i_key_down(pins[PIN_KEY_DOWN]), .i_key_disp(pins[PIN_KEY_DISP]), .i_key_sp_write(sp_wr),
        .i_key_sp_number(sp_num), .i_stopped_preset_output(preset), .i_auto_output(auto_out),
        .i_alarm_condition(alarm), .i_pv_value(pv), .i_diag_done(done), .i_ram_ok(oks[3]), .i_rom_ok(oks[2]),
        .i_system_data_ok(oks[1]), .i_calibration_ok(oks[0]), .i_param_error_flags(flags), .O_RUNNING(running),
        .O_MANUAL(manual), .O_SP_NUMBER(sp_out), .O_CONTROL_OUT(ctl_out), .O_CONTROL_ON(ctl_on), .O_ALARM(alm),
        .O_PV_DISPLAY(pv_disp), .O_DISPLAY_PAGE(page), .O_POWER_FAULT(pfault), .O_FAULT_CODE(fcode),
        .O_COMM_HALT(chalt), .O_PV_DP_BLINK(blink), .O_PARAM_ERROR(perr), .O_ERR_TENS(tens), .O_ERR_ONES(ones));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // value comparison with mismatch report
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // reset held four cycles, then pins settle
    task do_reset;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
    endtask : do_reset

    // one self-test result pulse
    task run_diag(input logic [3:0] ok, input logic [PERR_W-1:0] f);
        @(negedge clk);
        oks = ok;
        flags = f;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        repeat (4) @(negedge clk);
    endtask : run_diag

    // short key press and settle time
    task press(input int pos);
        i_panel_model.hold_key(pos, 3);
        repeat (8) @(negedge clk);
    endtask : press

    // watchdog against a hang
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end

    // main sequence
    initial begin
        {rst, sp_wr, alarm, done, sp_num, flags, oks} = '0;
        {preset, auto_out, pv} = {10'h055, 10'h123, 16'h1234};
        bad_count = 0;
        comparisons = 0;
        do_reset;
        i_panel_model.set_pin(PIN_RUN_STOP, 1'b1);
        run_diag(4'hF, 7'h00);
        check(ctl_on, 1);
        check(ctl_out, 16'h0123);
        press(PIN_KEY_MAN);
        check(manual, 1);
        repeat (3) press(PIN_KEY_UP);
        check(ctl_out, 16'h0126);
        press(PIN_KEY_DOWN);
        check(ctl_out, 16'h0125);
        press(PIN_KEY_MAN);
        check(manual, 0);
        i_panel_model.set_pin(PIN_AM_FORCE_MAN, 1'b1);
        i_panel_model.set_pin(PIN_AM_FORCE, 1'b1);
        press(PIN_KEY_MAN);
        check(manual, 1);
        i_panel_model.set_pin(PIN_AM_FORCE_MAN, 1'b0);
        press(PIN_KEY_MAN);
        check(manual, 0);
        i_panel_model.set_pin(PIN_AM_FORCE, 1'b0);
        press(PIN_KEY_MAN);
        i_panel_model.set_pin(PIN_RUN_STOP, 1'b0);
        press(PIN_KEY_UP);
        check(running, 0);
        check(ctl_out, 16'h0055);
        alarm = 1'b1;
        pv = 16'h0ABC;
        repeat (2) @(negedge clk);
        check(alm, 1);
        check(pv_disp, 16'h0ABC);
        alarm = 1'b0;
        i_panel_model.set_pin(PIN_RUN_STOP, 1'b1);
        repeat (8) @(negedge clk);
        check(ctl_out, 16'h0123);
        {sp_wr, sp_num} = 4'hD;
        @(negedge clk) sp_wr = 1'b0;
        @(negedge clk) check(sp_out, 5);
        i_panel_model.set_sp(3'h2);
        i_panel_model.set_pin(PIN_SP_CONTACT, 1'b1);
        repeat (8) @(negedge clk);
        {sp_wr, sp_num} = 4'hE;
        @(negedge clk) check(sp_out, 2);
        sp_wr = 1'b0;
        press(PIN_KEY_DISP);
        check(page, 1);
        i_panel_model.hold_key(PIN_KEY_DISP, 12);
        repeat (8) @(negedge clk);
        check(page, 2);
        i_panel_model.hold_key(PIN_KEY_DISP, 30);
        repeat (8) @(negedge clk);
        check(page, PAGE_OPERATING);
        for (int i = 0; i < 3; i++) begin
            do_reset;
            run_diag(bad_oks[i], 7'h00);
            check(fcode, codes[i]);
            check({pfault, chalt, ctl_on, ctl_out}, 16'h1800);
        end
        for (int i = 0; i < 3; i++) begin
            do_reset;
            run_diag(4'hF, perr_tbl[i]);
            check({perr, ctl_on}, 2);
            check({tens, ones}, {4'(perr_tbl[i] / 10), 4'(perr_tbl[i] % 10)});
        end
        do_reset;
        run_diag(4'hE, 7'h00);
        changes = 0;
        repeat (12) begin
            blink_prev = blink;
            @(negedge clk);
            if (blink !== blink_prev) changes++;
        end
        check(changes, 3);
        check({pfault, ctl_on}, 1);
        tally_and_finish;
    end
endmodule : controller_mode_and_fault_logic_test

// *** testbench/ctrl_mode_fault_chk.sv ***
// concurrent checks on the ports of the mode and fault logic
`timescale 1ns/100ps
module ctrl_mode_fault_chk
    import ctrl_mode_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic i_run_stop_contact_input,
    input wire logic i_sp_contact,
    input wire logic [SP_W-1:0] i_sp_contact_number,
    input wire logic i_am_force_contact,
    input wire logic i_am_force_manual,
    input wire logic [OUT_W-1:0] i_stopped_preset_output,
    input wire logic i_alarm_condition,
    input wire logic [15:0] i_pv_value,
    input wire logic O_RUNNING,
    input wire logic O_MANUAL,
    input wire logic [SP_W-1:0] O_SP_NUMBER,
    input wire logic [OUT_W-1:0] O_CONTROL_OUT,
    input wire logic O_CONTROL_ON,
    input wire logic O_ALARM,
    input wire logic [15:0] O_PV_DISPLAY,
    input wire logic O_POWER_FAULT,
    input wire logic O_COMM_HALT,
    input wire logic O_PARAM_ERROR,
    input wire logic [3:0] O_ERR_TENS,
    input wire logic [3:0] O_ERR_ONES
);
    // one clock domain, checks idle during reset
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    a_run_follows: assert property ((O_CONTROL_ON && $stable(i_run_stop_contact_input)) [*7]
        |=> O_RUNNING == $past(i_run_stop_contact_input)) else $error("run state does not follow contact");
    a_stop_preset: assert property ((!O_RUNNING && O_CONTROL_ON && $stable(i_stopped_preset_output)) [*3]
        |-> O_CONTROL_OUT == i_stopped_preset_output) else $error("stopped output is not the preset");
    a_fault_output_off: assert property (O_POWER_FAULT [*2]
        |-> !O_CONTROL_ON && O_CONTROL_OUT == OUT_ZERO) else $error("output live during memory fault");
    a_fault_comm_halt: assert property (O_POWER_FAULT [*3] |-> O_COMM_HALT)
        else $error("communication not halted on fault");
    a_err_digits: assert property (O_PARAM_ERROR |-> O_ERR_ONES <= 4'h9 && O_ERR_TENS <= 4'hC)
        else $error("error code digits out of range");
    a_param_output_off: assert property (O_PARAM_ERROR [*2] |-> !O_CONTROL_ON)
        else $error("output live during parameter error");
    a_alarm_passes: assert property (O_CONTROL_ON [*3] |-> O_ALARM == $past(i_alarm_condition))
        else $error("alarm output does not follow condition");
    a_pv_passes: assert property (!$past(I_RESET) |-> O_PV_DISPLAY == $past(i_pv_value))
        else $error("pv display does not follow measurement");
    a_sp_contact_wins: assert property ((i_sp_contact && $stable(i_sp_contact_number)) [*8]
        |=> O_SP_NUMBER == $past(i_sp_contact_number)) else $error("contact setpoint number not taken");
    a_force_mode: assert property ((i_am_force_contact && $stable(i_am_force_manual)) [*8]
        |=> O_MANUAL == $past(i_am_force_manual)) else $error("forced mode not applied");
endmodule : ctrl_mode_fault_chk

bind ctrl_mode_fault ctrl_mode_fault_chk i_ctrl_mode_fault_chk (.I_CLK_SYS, .I_RESET, .i_run_stop_contact_input,
    .i_sp_contact, .i_sp_contact_number, .i_am_force_contact, .i_am_force_manual, .i_stopped_preset_output,
    .i_alarm_condition, .i_pv_value, .O_RUNNING, .O_MANUAL, .O_SP_NUMBER, .O_CONTROL_OUT, .O_CONTROL_ON,
    .O_ALARM, .O_PV_DISPLAY, .O_POWER_FAULT, .O_COMM_HALT, .O_PARAM_ERROR, .O_ERR_TENS, .O_ERR_ONES);

// *** testbench/panel_model.sv ***
// front-panel key and contact input model driving the controller pins
`timescale 1ns/100ps
module panel_model
    import ctrl_mode_pkg::*;
(
    input wire logic i_clk,
    output logic [PIN_W-1:0] o_pins
);
    // all keys released and all contacts open at start
    initial o_pins = '0;

    // contact level change, made just after a falling edge
    task set_pin(input int pos, input logic v);
        @(negedge i_clk);
        o_pins[pos] = v;
    endtask : set_pin

    // setpoint number presented on the contacts
    task set_sp(input logic [SP_W-1:0] n);
        @(negedge i_clk);
        o_pins[PIN_SP_NUM_MSB:PIN_SP_NUM_LSB] = n;
    endtask : set_sp

    // key held for a number of cycles, then released
    task hold_key(input int pos, input int cycles);
        @(negedge i_clk);
        o_pins[pos] = 1'b1;
        repeat (cycles) @(negedge i_clk);
        o_pins[pos] = 1'b0;
    endtask : hold_key
endmodule : panel_model
